// [rtl/sps_defines.vh]
// Shared constants of the serial peripheral: modes, widths and timing counts.
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

`define SPS_BITS          8
`define SPS_CNT_W         3
`define SPS_LAST_BIT      3'h7
`define SPS_NSS_3W        2'h0
`define SPS_NSS_4W_SLV    2'h1
`define SPS_NSS_MST_BIT   1
`define SPS_CLK_PERIOD_NS 20
`define SPS_SYNC_LAT      3
`define SPS_SLH_MIN_CYC   6
`define SPS_SLH_MAX_CYC   8
`define SPS_SLH_WAIT      (`SPS_SLH_MIN_CYC - `SPS_SYNC_LAT + 1)
`define SPS_MST_HALF      4
`define SPS_NSS_RST       1'h1

`endif

// [rtl/sps_buf2.v]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module sps_buf2
#(
  parameter W = 8
)
(
  input  wire         clock,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] d0_ff;
  reg [W-1:0] d1_ff;
  reg [1:0]   cnt_ff;
  reg         in_ready_ff;
  reg         out_valid_ff;
  reg [1:0]   nxt_cnt;
  wire        push;
  wire        pop;

  assign push      = in_valid & in_ready_ff;
  assign pop       = out_valid_ff & out_ready;
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = d0_ff;

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (push & ~pop)
    begin
      nxt_cnt = cnt_ff + 2'h1;
    end
    else if (pop & ~push)
    begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      d0_ff        <= {W{1'b0}};
      d1_ff        <= {W{1'b0}};
      cnt_ff       <= 2'h0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
    end
    else
    begin
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= (nxt_cnt != 2'h2);
      out_valid_ff <= (nxt_cnt != 2'h0);
      if (pop & (cnt_ff == 2'h2))
      begin
        d0_ff <= d1_ff;
      end
      else if (push & ((cnt_ff == 2'h0) | pop))
      begin
        d0_ff <= in_data;
      end
      if (push & ~pop & (cnt_ff == 2'h1))
      begin
        d1_ff <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/sps_core.v]
// Serial peripheral core: slave shifting, clock options, master shifter and byte handshakes.
`timescale 1ns/1ns
`default_nettype none
`include "sps_defines.vh"
module sps_core
#(
  parameter MST_HALF = `SPS_MST_HALF
)
(
  input  wire       clock,
  input  wire       rst,
  input  wire       peripheral_enable_bit,
  input  wire       master_enable_bit,
  input  wire       clock_phase_sel,
  input  wire       clock_polarity_sel,
  input  wire [1:0] select_mode_field,
  input  wire       tx_valid,
  output wire       tx_ready,
  input  wire [7:0] tx_data,
  output wire       rx_valid,
  input  wire       rx_ready,
  output wire [7:0] rx_data,
  input  wire       done_clear,
  output wire       transfer_done_flag,
  output wire       rx_overrun,
  output wire       busy,
  output wire       slave_selected,
  input  wire       sck_in,
  output wire       sck_out,
  output wire       sck_oe,
  input  wire       mosi_in,
  output wire       mosi_out,
  output wire       mosi_oe,
  input  wire       miso_in,
  output wire       miso_out,
  output wire       miso_oe,
  input  wire       nss_in,
  output wire       nss_out,
  output wire       nss_oe
);
  localparam ST_IDLE = 3'h1;
  localparam ST_SLV  = 3'h2;
  localparam ST_MST  = 3'h4;
  localparam integer HALF_RELOAD = MST_HALF - 1;
  localparam integer SLH_WAIT    = `SPS_SLH_WAIT;

  reg [3:0]               sync1_ff;
  reg [3:0]               sync2_ff;
  reg                     sck_pv_ff;
  reg                     nss_pv_ff;
  reg                     en_pv_ff;
  reg [2:0]               st_ff;
  reg [2:0]               nxt_st;
  reg [7:0]               sr_ff;
  reg [7:0]               last_tx_ff;
  reg                     out_ff;
  reg [`SPS_CNT_W-1:0]    bit_cnt_ff;
  reg [3:0]               edge_cnt_ff;
  reg [7:0]               half_cnt_ff;
  reg                     msck_ff;
  reg [3:0]               slh_cnt_ff;
  reg [7:0]               rx_byte_ff;
  reg                     rx_push_ff;
  reg                     done_ff;
  reg                     ovr_ff;
  reg                     busy_ff;
  reg                     sel_ff;
  reg                     sck_out_ff;
  reg                     sck_oe_ff;
  reg                     mosi_oe_ff;
  reg                     miso_oe_ff;
  reg                     nss_out_ff;
  reg                     nss_oe_ff;

  wire       txq_valid;
  wire [7:0] txq_data;
  wire       rxq_in_ready;
  wire       sck_s;
  wire       mosi_s;
  wire       miso_s;
  wire       nss_s;
  wire       mode3w;
  wire       mode4s;
  wire       slv_en;
  wire       slv_sel;
  wire       nss_fall;
  wire       en_rise;
  wire       m_tick;
  wire       lead;
  wire       trail;
  wire       din;
  wire       smp;
  wire       shf;
  wire       byte_end;
  wire       cnt_clr;
  wire       slv_load;
  wire       m_start;
  wire       ld_evt;
  wire [7:0] nxt_tx;

  // Picks the trailing edge when sel is set, else the leading edge.
  function edge_pick;
    input sel;
    input l;
    input t;
    begin
      edge_pick = sel ? t : l;
    end
  endfunction

  // Every pin passes two flops before anything reads it.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      always @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          sync1_ff[gi] <= (gi == 3) ? `SPS_NSS_RST : 1'b0;
          sync2_ff[gi] <= (gi == 3) ? `SPS_NSS_RST : 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= (gi == 0) ? sck_in : (gi == 1) ? mosi_in :
                          (gi == 2) ? miso_in : nss_in;
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  // Polarity folds into the sampled clock so edge logic is mode-free.
  assign sck_s    = sync2_ff[0] ^ clock_polarity_sel;
  assign mosi_s   = sync2_ff[1];
  assign miso_s   = sync2_ff[2];
  assign nss_s    = sync2_ff[3];
  assign mode3w   = (select_mode_field == `SPS_NSS_3W);
  assign mode4s   = (select_mode_field == `SPS_NSS_4W_SLV);
  assign slv_en   = peripheral_enable_bit & ~master_enable_bit;
  assign slv_sel  = slv_en & (mode3w | (mode4s & ~nss_s));
  assign nss_fall = nss_pv_ff & ~nss_s;
  assign en_rise  = peripheral_enable_bit & ~en_pv_ff;
  assign m_tick   = st_ff[2] & (half_cnt_ff == 8'h00);

  // Unselected slaves ignore the clock entirely.
  assign lead  = st_ff[2] ? (m_tick & ~msck_ff) : (slv_sel & sck_s & ~sck_pv_ff);
  assign trail = st_ff[2] ? (m_tick & msck_ff) : (slv_sel & ~sck_s & sck_pv_ff);
  assign din   = st_ff[2] ? miso_s : mosi_s;
  assign smp   = edge_pick(clock_phase_sel, lead, trail);
  assign shf   = edge_pick(~clock_phase_sel, lead, trail);
  assign byte_end = smp & (bit_cnt_ff == `SPS_LAST_BIT);

  // In three-wire mode only a disable clears the counter.
  assign cnt_clr  = ~peripheral_enable_bit | (slv_en & mode4s & nss_fall);
  assign slv_load = (slv_en & ((mode4s & nss_fall) | (mode3w & en_rise)))
                    | (st_ff[1] & byte_end);
  // Slave never begins a transfer; only the master start pops on its own.
  assign m_start  = st_ff[0] & peripheral_enable_bit & master_enable_bit & txq_valid;
  assign ld_evt   = slv_load | m_start;
  assign nxt_tx   = txq_valid ? txq_data : last_tx_ff;

  sps_buf2 #(.W(`SPS_BITS)) u_txq
  (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (txq_valid),
    .out_ready (ld_evt),
    .out_data  (txq_data)
  );

  sps_buf2 #(.W(`SPS_BITS)) u_rxq
  (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (rx_push_ff),
    .in_ready  (rxq_in_ready),
    .in_data   (rx_byte_ff),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
      begin
        if (m_start)
        begin
          nxt_st = ST_MST;
        end
        else if (slv_sel)
        begin
          nxt_st = ST_SLV;
        end
      end
      ST_SLV:
      begin
        if (~slv_sel)
        begin
          nxt_st = ST_IDLE;
        end
      end
      ST_MST:
      begin
        if (~peripheral_enable_bit | (m_tick & (edge_cnt_ff == 4'hF)))
        begin
          nxt_st = ST_IDLE;
        end
      end
      default:
      begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sck_pv_ff   <= 1'b0;
      nss_pv_ff   <= `SPS_NSS_RST;
      en_pv_ff    <= 1'b0;
      st_ff       <= ST_IDLE;
      sr_ff       <= 8'h00;
      last_tx_ff  <= 8'h00;
      out_ff      <= 1'b0;
      bit_cnt_ff  <= {`SPS_CNT_W{1'b0}};
      edge_cnt_ff <= 4'h0;
      half_cnt_ff <= 8'h00;
      msck_ff     <= 1'b0;
      slh_cnt_ff  <= 4'h0;
      rx_byte_ff  <= 8'h00;
      rx_push_ff  <= 1'b0;
      done_ff     <= 1'b0;
      ovr_ff      <= 1'b0;
    end
    else
    begin
      sck_pv_ff <= sck_s;
      nss_pv_ff <= nss_s;
      en_pv_ff  <= peripheral_enable_bit;
      st_ff     <= nxt_st;
      // Sample shifts in MSB first; the byte completes on the eighth sample.
      if (smp)
      begin
        sr_ff <= {sr_ff[6:0], din};
      end
      if (cnt_clr | m_start)
      begin
        bit_cnt_ff <= {`SPS_CNT_W{1'b0}};
      end
      else if (smp)
      begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      rx_push_ff <= byte_end;
      if (byte_end)
      begin
        rx_byte_ff <= {sr_ff[6:0], din};
      end
      // Loading overrides the sample so the next byte starts clean.
      if (ld_evt)
      begin
        sr_ff      <= nxt_tx;
        last_tx_ff <= nxt_tx;
      end
      if (ld_evt & ~byte_end)
      begin
        out_ff <= nxt_tx[7];
      end
      else if (shf)
      begin
        out_ff <= sr_ff[7];
      end
      else if (slh_cnt_ff == 4'h1)
      begin
        out_ff <= sr_ff[7];
      end
      // Second-edge phase: the wait plus the synchroniser lag lands in 6..8 cycles.
      if (byte_end & st_ff[1] & clock_phase_sel)
      begin
        slh_cnt_ff <= SLH_WAIT[3:0];
      end
      else if (slh_cnt_ff != 4'h0)
      begin
        slh_cnt_ff <= slh_cnt_ff - 4'h1;
      end
      // Master clock: the first edge comes a full half period after the load.
      if (m_start)
      begin
        half_cnt_ff <= HALF_RELOAD[7:0];
        edge_cnt_ff <= 4'h0;
        msck_ff     <= 1'b0;
      end
      else if (st_ff[2])
      begin
        if (m_tick)
        begin
          half_cnt_ff <= HALF_RELOAD[7:0];
          edge_cnt_ff <= edge_cnt_ff + 4'h1;
          msck_ff     <= ~msck_ff;
        end
        else
        begin
          half_cnt_ff <= half_cnt_ff - 8'h01;
        end
      end
      else
      begin
        msck_ff <= 1'b0;
      end
      // A new completion wins over a clear in the same cycle.
      if (byte_end)
      begin
        done_ff <= 1'b1;
      end
      else if (done_clear)
      begin
        done_ff <= 1'b0;
      end
      // The master cannot be stalled, so a full receive queue drops the byte.
      if (rx_push_ff & ~rxq_in_ready)
      begin
        ovr_ff <= 1'b1;
      end
      else if (done_clear)
      begin
        ovr_ff <= 1'b0;
      end
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busy_ff    <= 1'b0;
      sel_ff     <= 1'b0;
      sck_out_ff <= 1'b0;
      sck_oe_ff  <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
      nss_out_ff <= `SPS_NSS_RST;
      nss_oe_ff  <= 1'b0;
    end
    else
    begin
      busy_ff    <= st_ff[2] | (st_ff[1] & (bit_cnt_ff != {`SPS_CNT_W{1'b0}}));
      sel_ff     <= slv_sel;
      sck_out_ff <= msck_ff ^ clock_polarity_sel;
      sck_oe_ff  <= peripheral_enable_bit & master_enable_bit;
      mosi_oe_ff <= peripheral_enable_bit & master_enable_bit;
      miso_oe_ff <= slv_sel;
      nss_out_ff <= select_mode_field[0];
      nss_oe_ff  <= peripheral_enable_bit & master_enable_bit &
                    select_mode_field[`SPS_NSS_MST_BIT];
    end
  end

  assign transfer_done_flag = done_ff;
  assign rx_overrun         = ovr_ff;
  assign busy               = busy_ff;
  assign slave_selected     = sel_ff;
  assign sck_out            = sck_out_ff;
  assign sck_oe             = sck_oe_ff;
  assign mosi_out           = out_ff;
  assign mosi_oe            = mosi_oe_ff;
  assign miso_out           = out_ff;
  assign miso_oe            = miso_oe_ff;
  assign nss_out            = nss_out_ff;
  assign nss_oe             = nss_oe_ff;
endmodule
`default_nettype wire

// [sim/sps_core_checker.sv]
// Concurrent checks on the ports of the serial peripheral core.
`timescale 1ns/1ns
`default_nettype none
module sps_core_checker
#(
  parameter MST_HALF = 4
)
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       peripheral_enable_bit,
  input wire logic       master_enable_bit,
  input wire logic [1:0] select_mode_field,
  input wire logic       nss_in,
  input wire logic       miso_oe,
  input wire logic       mosi_oe,
  input wire logic       sck_oe,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       transfer_done_flag,
  input wire logic       done_clear
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  wire slv4 = peripheral_enable_bit && !master_enable_bit && select_mode_field == 2'h1;
  wire slv3 = peripheral_enable_bit && !master_enable_bit && select_mode_field == 2'h0;
  a_select_drive: assert property (slv4 && $fell(nss_in) |-> ##[1:4] miso_oe)
    else $error("miso not driven after select fell");
  a_deselect_release: assert property (slv4 && $rose(nss_in) |-> ##[1:4] !miso_oe)
    else $error("miso not released after select rose");
  a_unsel_quiet: assert property ((slv4 && nss_in) [*5] |-> !miso_oe)
    else $error("unselected slave drives miso");
  a_off_quiet: assert property ((!peripheral_enable_bit) [*3] |-> !(miso_oe || mosi_oe))
    else $error("disabled block drives a pin");
  a_slave_no_clock: assert property ((!master_enable_bit) [*3] |-> !sck_oe && !mosi_oe)
    else $error("slave drives clock or mosi");
  a_three_wire_on: assert property (slv3 [*5] |-> miso_oe)
    else $error("three-wire slave leaves miso released");
  a_flag_holds: assert property (transfer_done_flag && !done_clear |=> transfer_done_flag)
    else $error("done flag dropped without clear");
  a_rx_stands: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive head changed before read");
  cover property (rx_valid && rx_ready);
  cover property ($rose(transfer_done_flag));
  cover property (slv4 && $fell(nss_in));
endmodule
bind sps_core sps_core_checker #(.MST_HALF(MST_HALF)) u_chk (.clock(clock), .rst(rst),
  .peripheral_enable_bit(peripheral_enable_bit), .master_enable_bit(master_enable_bit),
  .select_mode_field(select_mode_field), .nss_in(nss_in), .miso_oe(miso_oe),
  .mosi_oe(mosi_oe), .sck_oe(sck_oe), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_data(rx_data), .transfer_done_flag(transfer_done_flag), .done_clear(done_clear));
`default_nettype wire

// [sim/sps_master_model.sv]
// Behavioural external master that clocks the slave under test.
`timescale 1ns/1ns
`default_nettype none
module sps_master_model
(
  output logic      sck,
  output logic      mosi,
  output logic      nss,
  input  wire logic miso
);
  initial
  begin
    sck = 1'h0;
    mosi = 1'h0;
    nss = 1'h1;
  end
  // Half period in ns; callers keep it at five system clocks or more.
  task automatic xfer(input logic [7:0] tx, input logic pol, pha, sel, input int bits, hp,
                      output logic [7:0] rx);
    int i;
    begin
      rx = 8'h00;
      // Settle the idle clock level before select falls, so no false edge is seen.
      sck = pol;
      #(hp);
      nss = !sel;
      mosi = tx[7];
      #(hp);
      for (i = 0; i < bits; i++)
      begin
        if (pha)
          mosi = tx[7 - i];
        sck = !pol;
        if (!pha)
          rx = {rx[6:0], miso};
        #(hp);
        sck = pol;
        if (pha)
          rx = {rx[6:0], miso};
        else if (i < 7)
          mosi = tx[6 - i];
        #(hp);
      end
      nss = 1'h1;
      // A released data line must not keep showing its last bit.
      mosi = !mosi;
    end
  endtask
endmodule
`default_nettype wire

// [sim/test_spi_slave_mode_and_clock_options.sv]
// Self-checking bench for the serial peripheral core in slave mode.
`timescale 1ns/1ns
`default_nettype none
module test_spi_slave_mode_and_clock_options;
  logic       clock, rst, en, mst, cpha, cpol, tx_valid, rx_ready, done_clear, miso_hold;
  logic [1:0] fld;
  logic [7:0] tx_data, got, b0, b1;
  logic [7:0] mb [3];
  wire  [7:0] rx_data;
  wire        tx_ready, rx_valid, flag, ovr, sck_out, sck_oe, mosi_out, mosi_oe;
  wire        miso_out, miso_oe, nss_out, nss_oe, m_sck, m_mosi, m_nss, busy_w, sel_w;
  wire        sck_w  = sck_oe ? sck_out : m_sck;
  wire        mosi_w = mosi_oe ? mosi_out : m_mosi;
  wire        nss_w  = nss_oe ? nss_out : m_nss;
  wire        miso_w = miso_oe ? miso_out : !miso_hold;
  int         error_cnt, total_checks, cyc, i, k;
  sps_core u_dut (.clock(clock), .rst(rst), .peripheral_enable_bit(en),
    .master_enable_bit(mst), .clock_phase_sel(cpha), .clock_polarity_sel(cpol),
    .select_mode_field(fld), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .done_clear(done_clear),
    .transfer_done_flag(flag), .rx_overrun(ovr), .busy(busy_w), .slave_selected(sel_w),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .nss_in(nss_w), .nss_out(nss_out), .nss_oe(nss_oe));
  sps_master_model u_mst (.sck(m_sck), .mosi(m_mosi), .nss(m_nss), .miso(miso_w));
  initial
  begin
    clock = 1'h0;
    forever #10 clock = !clock;
  end
  // An undriven miso flips each cycle so a stale bit cannot pass.
  always @(posedge clock)
    miso_hold <= miso_w;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'h1;
    while (!tx_ready)
      tick(1);
    tick(1);
    tx_valid = 1'h0;
    tick(1);
  endtask
  task frame(input logic [7:0] m, input int bits);
    u_mst.xfer(m, cpol, cpha, fld == 2'h1, bits, 100 + $urandom % 40, got);
    tick(10);
  endtask
  task pop(input logic [7:0] e);
    chk("rx_valid", {7'h0, rx_valid}, 8'h01);
    chk("rx_data", rx_data, e);
    rx_ready = 1'h1;
    tick(1);
    rx_ready = 1'h0;
    tick(2);
  endtask
  // Settings change only while the block is off.
  task setup(input logic [1:0] f, input logic p, q);
    en = 1'h0;
    tick(2);
    fld = f;
    cpol = p;
    cpha = q;
    tick(2);
    en = 1'h1;
    tick(4);
  endtask
  task flag_chk;
    chk("done_flag", {7'h0, flag}, 8'h01);
    done_clear = 1'h1;
    tick(1);
    done_clear = 1'h0;
    tick(1);
    chk("done_flag", {7'h0, flag}, 8'h00);
  endtask
  initial
  begin
    {en, mst, cpha, cpol, tx_valid, rx_ready, done_clear, miso_hold} = 8'h00;
    fld = 2'h1;
    tx_data = 8'h00;
    rst = 1'h1;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    b0 = $urandom(91);
    tick(16);
    rst = 1'h0;
    tick(2);
    for (i = 0; i < 4; i++)
    begin
      setup(2'h1, i[1], i[0]);
      b0 = $urandom;
      b1 = (i == 3) ? 8'h01 : $urandom;
      push(b0);
      push(b1);
      chk("tx_ready_full", {7'h0, tx_ready}, 8'h00);
      for (k = 0; k < 3; k++)
      begin
        mb[k] = (i == 0 && k == 0) ? 8'h80 : $urandom;
        frame(mb[k], 8);
        chk("miso_byte", got, (k == 0) ? b0 : b1);
        flag_chk;
        pop(mb[k]);
      end
    end
    $display("test clock modes done");
    frame(8'h3C, 4);
    chk("slave_sel", {7'h0, sel_w}, 8'h00);
    mb[0] = $urandom;
    frame(mb[0], 8);
    pop(mb[0]);
    flag_chk;
    $display("test select realign done");
    setup(2'h0, 1'h0, 1'h0);
    frame(8'hC3, 3);
    chk("busy", {7'h0, busy_w}, 8'h01);
    chk("slave_sel", {7'h0, sel_w}, 8'h01);
    setup(2'h0, 1'h0, 1'h0);
    mb[0] = $urandom;
    frame(mb[0], 8);
    pop(mb[0]);
    flag_chk;
    $display("test three wire done");
    setup(2'h1, 1'h0, 1'h1);
    for (k = 0; k < 3; k++)
    begin
      mb[k] = $urandom;
      frame(mb[k], 8);
    end
    chk("rx_overrun", {7'h0, ovr}, 8'h01);
    pop(mb[0]);
    pop(mb[1]);
    chk("rx_valid", {7'h0, rx_valid}, 8'h00);
    $display("test receive overrun done");
    complete_run;
  end
endmodule
`default_nettype wire
